// file: src/ttxhp_top.sv
// Host port, steering logic and alert line of the tone transceiver
// Summary of operation
// R01: Data lines float when chip select high or strobe inactive for style.
// R02: Direction input is read/write select or active-low write strobe.
// R03: Strobe is data strobe or read strobe; toggled only when accessing.
// R04: Host qualifies chip select with its address strobe before use.
// R05: Register choose level during access picks the addressed register.
// R06: Interrupt mode pulls alert low after tone burst sent or received.
// R07: Call progress mode drives alert with the squared input signal.
// R08: Early valid-pair goes high once a valid tone pair is detected.
// R09: Early valid-pair drops low on any loss of the tone pair.
// R10: Validation node above threshold registers pair and updates latch.
// R11: Validation node below threshold re-arms for a new tone pair.
// R12: Guard drive depends on early valid-pair and validation node level.
// R13: Registered pair's 4-bit code is latched into receive data register.
// R14: Guard drive stays high while early valid-pair stays high.
// R15: Delayed steering flag set after settling; alert low while it holds. Code pulls it low only with ctrl_reg[1] set and ctrl_reg[0] clear.
// R16: Read data driven only during a qualified read access.
module ttxhp_top
    import ttxhp_pkg::*;
#(
    parameter int data_w = nibble_w
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Host parallel port
    input wire logic chip_sel_n,
    input wire logic register_choose,
    input wire logic access_strobe,
    input wire logic rw_dir,
    input wire logic host_style,
    input wire logic [data_w-1:0] host_nibble_bus_in,
    output logic [data_w-1:0] host_nibble_bus_out,
    output logic host_nibble_bus_oe_n,
    // Detector and transmitter events
    input wire logic pair_detect,
    input wire logic [data_w-1:0] pair_code,
    input wire logic tx_burst_done,
    input wire logic cp_square_in,
    // Steering node, three-state style three signals
    input wire logic validation_node_in,
    output logic guard_drive_out,
    output logic guard_drive_oe_n,
    // Receiver and alert outputs
    output logic early_valid_pair,
    output logic host_alert_line_out,
    output logic host_alert_line_oe_n,
    // Visible state
    output logic [data_w-1:0] rx_code,
    output logic [data_w-1:0] ctrl_reg
);
    logic rd_access;
    logic wr_access;
    logic wr_access_d;
    logic latched;
    logic next_latched;
    logic dsteer;
    logic next_dsteer;
    logic tx_done;
    logic next_tx_done;
    logic [data_w-1:0] next_rx_code;
    logic [data_w-1:0] next_ctrl;
    logic [data_w-1:0] status;
    logic [data_w-1:0] next_bus_out;
    logic settle_go;
    logic settle_done;
    logic status_read;
    logic rd_access_d;

    // Qualified access decode; chip select is assumed pre-qualified [R04]
    always_comb begin
        if (host_style == host_style_strobe) begin
            rd_access = !chip_sel_n && access_strobe && rw_dir; // [R02] [R03]
            wr_access = !chip_sel_n && access_strobe && !rw_dir; // [R02]
        end else begin
            rd_access = !chip_sel_n && !access_strobe; // [R03]
            wr_access = !chip_sel_n && !rw_dir; // [R02]
        end
    end

    // Bus floats outside a read access [R01] [R16]
    assign host_nibble_bus_oe_n = !rd_access;

    // Early valid-pair follows detection with no hold [R08] [R09]
    assign early_valid_pair = pair_detect;

    // Guard drive high while latched and pair present, else low [R12] [R14]
    assign guard_drive_out = latched && pair_detect;
    // Drive high while registered, low after loss to discharge the node;
    // released while the time constant is still charging [R12] [R14]
    assign guard_drive_oe_n = !((latched && pair_detect)
        || (!pair_detect && validation_node_in));

    assign status = {dsteer, rx_code != rx_code_reset, tx_done,
        dsteer || tx_done};
    assign settle_go = validation_node_in && !latched;
    assign status_read = rd_access_d && !rd_access
        && register_choose == reg_sel_status;

    ttxhp_settle u_settle (
        .clk(clk),
        .rst_n(rst_n),
        .start(settle_go),
        .done(settle_done)
    );

    // Steering, latch and flags; hardware set wins over the read clear
    always_comb begin
        next_latched = latched;
        next_rx_code = rx_code;
        next_dsteer = dsteer;
        next_tx_done = tx_done;
        next_ctrl = ctrl_reg;
        next_bus_out = host_nibble_bus_out;
        if (validation_node_in && !latched) begin
            next_latched = 1'b1; // [R10]
            next_rx_code = pair_code; // [R13]
        end else if (!validation_node_in) begin
            next_latched = 1'b0; // [R11]
        end
        if (status_read) begin
            next_dsteer = 1'b0;
            next_tx_done = 1'b0;
        end
        if (settle_done) begin
            next_dsteer = 1'b1; // [R15]
        end
        if (tx_burst_done) begin
            next_tx_done = 1'b1; // [R06]
        end
        // Write on the trailing edge of the write strobe
        if (wr_access_d && !wr_access
            && register_choose == reg_sel_status) begin // [R05]
            next_ctrl = host_nibble_bus_in;
        end
        if (rd_access) begin
            next_bus_out = (register_choose == reg_sel_data)
                ? rx_code : status; // [R05] [R16]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latched <= 1'b0;
            rx_code <= rx_code_reset;
            dsteer <= 1'b0;
            tx_done <= 1'b0;
            ctrl_reg <= ctrl_reset;
            host_nibble_bus_out <= 4'h0;
            wr_access_d <= 1'b0;
            rd_access_d <= 1'b0;
        end else begin
            latched <= next_latched;
            rx_code <= next_rx_code;
            dsteer <= next_dsteer;
            tx_done <= next_tx_done;
            ctrl_reg <= next_ctrl;
            host_nibble_bus_out <= next_bus_out;
            wr_access_d <= wr_access;
            rd_access_d <= rd_access;
        end
    end

    // Alert line: open drain, so only a low is ever driven [R06] [R07]
    assign host_alert_line_out = 1'b0;
    always_comb begin
        if (ctrl_reg[0] == alert_mode_cp) begin
            host_alert_line_oe_n = cp_square_in; // [R07]
        end else if (ctrl_reg[1]) begin
            host_alert_line_oe_n = !(dsteer || tx_done); // [R06] [R15]
        end else begin
            host_alert_line_oe_n = 1'b1;
        end
    end

    // One clock domain: shared clocking, checks off during reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_bus_float: assert property ( // [R01]
        chip_sel_n |-> host_nibble_bus_oe_n)
        else $error("data bus driven while deselected");
    chk_evp_rise: assert property ( // [R08]
        pair_detect |-> early_valid_pair)
        else $error("early valid pair missing");
    chk_evp_follow: assert property ( // [R09]
        !pair_detect |-> !early_valid_pair)
        else $error("early valid pair held after loss");
    chk_latch_code: assert property ( // [R13]
        (validation_node_in && !latched) |=> rx_code == $past(pair_code))
        else $error("code not latched on registration");
    chk_rearm: assert property ( // [R11]
        !validation_node_in |=> !latched)
        else $error("steering not re-armed");
    chk_guard_high: assert property ( // [R14]
        (latched && pair_detect) |-> guard_drive_out && !guard_drive_oe_n)
        else $error("guard drive not high");
    chk_guard_reset: assert property ( // [R12]
        (!pair_detect && validation_node_in)
        |-> !guard_drive_out && !guard_drive_oe_n)
        else $error("guard drive not discharging node");
    chk_dsteer_delay: assert property ( // [R15]
        (validation_node_in && !latched && !status_read)
        ##1 (validation_node_in [*5]) |=> ##[0:2] dsteer)
        else $error("delayed steering flag late");
    chk_irq_alert: assert property ( // [R06]
        (ctrl_reg[1:0] == 2'b10 && dsteer) |-> !host_alert_line_oe_n)
        else $error("alert not pulled low");
    chk_cp_follow: assert property ( // [R07]
        ctrl_reg[0] |-> host_alert_line_oe_n == cp_square_in)
        else $error("call progress not followed");
    chk_write_split: assert property ( // [R02]
        (host_style && !chip_sel_n && !rw_dir && access_strobe)
        |-> host_nibble_bus_oe_n)
        else $error("bus driven during split write");
    chk_data_write: assert property ( // [R05]
        (wr_access_d && !wr_access && register_choose == reg_sel_data)
        |=> ctrl_reg == $past(ctrl_reg))
        else $error("write to receive register changed control");
    chk_read_data: assert property ( // [R05]
        (rd_access && register_choose == reg_sel_data)
        |=> host_nibble_bus_out == $past(rx_code))
        else $error("receive code not presented on read");
    cov_read: cover property (rd_access ##1 !rd_access);
    cov_register: cover property (settle_done);
    cov_tx: cover property (tx_burst_done);
    cov_cp: cover property (ctrl_reg[0] && !cp_square_in);
    cov_rearm: cover property (latched ##1 !latched);
endmodule

// file: src/ttxhp_pkg.sv
// Shared constants for the tone transceiver host port
package ttxhp_pkg;
    // Host style on the strobe pair
    localparam logic host_style_strobe = 1'b0;
    localparam logic host_style_split = 1'b1;
    // Register choose values
    localparam logic reg_sel_data = 1'b0;
    localparam logic reg_sel_status = 1'b1;
    // Alert line function
    localparam logic alert_mode_irq = 1'b0;
    localparam logic alert_mode_cp = 1'b1;
    // Status field positions
    localparam int stat_irq_bit = 0;
    localparam int stat_tx_done_bit = 1;
    localparam int stat_rx_full_bit = 2;
    localparam int stat_dsteer_bit = 3;
    // Nibble width and reset values
    localparam int nibble_w = 4;
    localparam logic [3:0] rx_code_reset = 4'h0;
    localparam logic [3:0] ctrl_reset = 4'h0;
    // Settling delay of the output latch before delayed steering
    localparam int settle_ns = 200;
    localparam int clk_period_ns = 40;
    localparam int settle_cycles = (settle_ns + clk_period_ns - 1)
        / clk_period_ns;
    localparam logic [3:0] settle_cnt_w = 4'(settle_cycles);
endpackage

// file: src/ttxhp_settle.sv
// Settling delay counter for the delayed steering flag
module ttxhp_settle
    import ttxhp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Start pulse and completion pulse
    input wire logic start,
    output logic done
);
    logic [3:0] count;
    logic [3:0] next_count;
    logic next_done;

    // Count down from the settle figure after each registration
    always_comb begin
        next_count = count;
        next_done = 1'b0;
        if (start) begin
            next_count = settle_cnt_w;
        end else if (count != 4'h0) begin
            next_count = count - 4'h1;
            next_done = (count == 4'h1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= 4'h0;
            done <= 1'b0;
        end else begin
            count <= next_count;
            done <= next_done;
        end
    end
endmodule

// file: bench/ttxhp_host_model.sv
// Host microcontroller model for the nibble bus of the tone port
module ttxhp_host_model
    import ttxhp_pkg::*;
(
    // Clock and host style
    input wire logic clk,
    input wire logic host_style,
    // Strobes and select toward the device
    output logic chip_sel_n,
    output logic register_choose,
    output logic access_strobe,
    output logic rw_dir,
    // Nibble bus, resolved here
    output logic [3:0] host_nibble_bus_in,
    input wire logic [3:0] host_nibble_bus_out,
    input wire logic host_nibble_bus_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] host_data = 4'h0;
    logic host_drv = 1'b0;
    logic [3:0] last = 4'h0;
    // Floating bus shows inverse of last level, never a lucky match
    always_comb begin
        if (!host_nibble_bus_oe_n) host_nibble_bus_in = host_nibble_bus_out;
        else if (host_drv) host_nibble_bus_in = host_data;
        else host_nibble_bus_in = ~last;
    end
    // Remember last resolved level
    always @(posedge clk) last <= host_nibble_bus_in;
    initial begin
        chip_sel_n = 1'b1;
        register_choose = 1'b0;
        access_strobe = 1'b0;
        rw_dir = 1'b1;
    end
    // Idle levels differ per style; select dropped between accesses
    task automatic idle();
        chip_sel_n = 1'b1;
        access_strobe = host_style;
        rw_dir = 1'b1;
        host_drv = 1'b0;
    endtask
    // Read: strobe active two cycles, sample at the end
    task automatic rd(input logic rs, output logic [3:0] d, output logic oe);
        @(negedge clk);
        chip_sel_n = 1'b0;
        register_choose = rs;
        rw_dir = 1'b1;
        access_strobe = ~host_style;
        repeat (2) @(negedge clk);
        d = host_nibble_bus_in;
        oe = host_nibble_bus_oe_n;
        idle();
    endtask
    // Write: data held through the closing cycle
    task automatic wr(input logic rs, input logic [3:0] d);
        @(negedge clk);
        chip_sel_n = 1'b0;
        register_choose = rs;
        host_data = d;
        host_drv = 1'b1;
        rw_dir = 1'b0;
        if (!host_style) access_strobe = 1'b1;
        @(negedge clk);
        if (host_style) rw_dir = 1'b1;
        else access_strobe = 1'b0;
        @(negedge clk);
        idle();
    endtask
endmodule

// file: bench/tb.sv
// Self-checking bench for the tone transceiver host port
module tb
    import ttxhp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, host_style = 1'b0, pair_detect = 1'b0;
    logic tx_burst_done = 1'b0, cp_square_in = 1'b1, validation_node_in = 1'b0;
    logic [3:0] pair_code = 4'h0, bus_in, bus_out, rx_code, ctrl_reg, d;
    logic cs_n, rs, strobe, rw, bus_oe_n, gd_out, gd_oe_n, evp, al_out;
    logic oe, al_oe_n;
    int n_errors = 0, compares = 0;
    ttxhp_top dut (.clk(clk), .rst_n(rst_n), .chip_sel_n(cs_n),
        .register_choose(rs), .access_strobe(strobe), .rw_dir(rw),
        .host_style(host_style), .host_nibble_bus_in(bus_in),
        .host_nibble_bus_out(bus_out), .host_nibble_bus_oe_n(bus_oe_n),
        .pair_detect(pair_detect), .pair_code(pair_code),
        .tx_burst_done(tx_burst_done), .cp_square_in(cp_square_in),
        .validation_node_in(validation_node_in), .guard_drive_out(gd_out),
        .guard_drive_oe_n(gd_oe_n), .early_valid_pair(evp),
        .host_alert_line_out(al_out), .host_alert_line_oe_n(al_oe_n),
        .rx_code(rx_code), .ctrl_reg(ctrl_reg));
    ttxhp_host_model host (.clk(clk), .host_style(host_style),
        .chip_sel_n(cs_n), .register_choose(rs), .access_strobe(strobe),
        .rw_dir(rw), .host_nibble_bus_in(bus_in),
        .host_nibble_bus_out(bus_out), .host_nibble_bus_oe_n(bus_oe_n));
    // 25 MHz clock
    initial forever #20 clk = ~clk;
    task automatic chk(input logic ok, input string m);
        compares++;
        if (!ok) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Writes to data register ignored; control write and status read
    task automatic t_regs(input logic style, input logic [3:0] old_ctrl,
        input logic [3:0] new_ctrl);
        host_style = style;
        host.idle();
        host.wr(reg_sel_data, 4'h3);
        repeat (2) @(negedge clk);
        chk(ctrl_reg === old_ctrl, "data reg write took");
        host.wr(reg_sel_status, new_ctrl);
        repeat (2) @(negedge clk);
        chk(ctrl_reg === new_ctrl, "control write lost");
        host.rd(reg_sel_status, d, oe);
        chk(oe === 1'b0 && d === 4'h0, "status read bad");
        @(negedge clk);
        chk(bus_oe_n === 1'b1, "bus not floated");
    endtask
    // Pair detect, registration, delayed steering, re-arm
    task automatic t_steer();
        pair_code = 4'h9;
        pair_detect = 1'b1;
        @(negedge clk);
        chk(evp === 1'b1 && gd_oe_n === 1'b1, "early pair");
        validation_node_in = 1'b1;
        @(negedge clk);
        pair_code = 4'h5;
        chk(rx_code === 4'h9, "latch");
        chk(gd_out === 1'b1 && gd_oe_n === 1'b0, "guard high");
        host.rd(reg_sel_data, d, oe);
        chk(oe === 1'b0 && d === 4'h9, "data read");
        repeat (9) @(negedge clk);
        chk(rx_code === 4'h9 && al_oe_n === 1'b0, "steer");
        host.rd(reg_sel_status, d, oe);
        chk(d === 4'hd, "status after steer");
        pair_detect = 1'b0;
        @(negedge clk);
        chk(evp === 1'b0 && al_oe_n === 1'b1, "pair loss");
        chk(gd_out === 1'b0 && gd_oe_n === 1'b0, "guard reset");
        validation_node_in = 1'b0;
        repeat (2) @(negedge clk);
        pair_detect = 1'b1;
        validation_node_in = 1'b1;
        repeat (2) @(negedge clk);
        chk(rx_code === 4'h5, "re-arm");
        pair_detect = 1'b0;
        validation_node_in = 1'b0;
        repeat (10) @(negedge clk);
        host.rd(reg_sel_status, d, oe);
        chk(d === 4'hd, "second steer");
    endtask
    // Burst transmitted raises alert and status flag
    task automatic t_tx();
        tx_burst_done = 1'b1;
        @(negedge clk);
        tx_burst_done = 1'b0;
        repeat (2) @(negedge clk);
        chk(al_oe_n === 1'b0, "tx alert");
        host.rd(reg_sel_status, d, oe);
        chk(d === 4'h7, "tx status");
    endtask
    // Call progress mode squares the input onto the alert line
    task automatic t_cp();
        host.wr(reg_sel_status, 4'h1);
        for (int i = 0; i < 4; i++) begin
            cp_square_in = i[0];
            repeat (3) @(negedge clk);
            chk(al_oe_n === cp_square_in, "cp follow");
        end
    endtask
    // Main sequence after a 20 cycle reset
    initial begin
        repeat (20) @(negedge clk);
        chk(rx_code === rx_code_reset, "rst code");
        chk(ctrl_reg === ctrl_reset, "rst ctrl");
        chk(bus_oe_n === 1'b1 && al_oe_n === 1'b1, "rst outs");
        chk(al_out === 1'b0, "alert drives high");
        rst_n = 1'b1;
        t_regs(host_style_split, ctrl_reset, 4'hc);
        t_regs(host_style_strobe, 4'hc, 4'h2);
        t_steer();
        t_tx();
        t_cp();
        end_of_test();
    end
    // Watchdog well beyond the hundred or so cycles of the tests
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        end_of_test();
    end
endmodule
